/* File: design/vim_pkg.sv */
// Constants and types shared by the voltage-id input monitor
package vim_pkg;

    // Register offsets
    localparam logic [7:0] OFS_INT_STATUS_TWO  = 8'h42;
    localparam logic [7:0] OFS_VOLTAGE_ID_GPIO = 8'h43;
    localparam logic [7:0] OFS_INT_MASK_TWO    = 8'h75;
    localparam logic [7:0] OFS_CONFIG_FIVE     = 8'h7c;

    // Field positions
    localparam int BIT_FLAG_RAIL12_OR_VC = 0;
    localparam int BIT_SHARED_ID         = 5;
    localparam int BIT_THRESHOLD_SELECT  = 6;
    localparam int BIT_SIXTH_INPUT_SEL   = 7;
    localparam int BIT_MASK_VC           = 0;
    localparam int BIT_GPIO_ENABLE       = 4;
    localparam int BIT_PIN6_DIR          = 2;
    localparam int BIT_PIN6_LEVEL        = 3;

    // Reset values
    localparam logic [7:0] RST_CONFIG_FIVE = 8'h00;
    localparam logic       RST_MASK_VC     = 1'b0;
    localparam logic       RST_THRESHOLD   = 1'b0;
    localparam logic       RST_SIXTH_SEL   = 1'b0;
    localparam logic [5:0] RST_GPIO_POL    = 6'h00;

    // Timing
    localparam int CLK_PERIOD_NS       = 20;
    localparam int CHANGE_WINDOW_NS    = 11000;
    localparam int CHANGE_WINDOW_CYC   = CHANGE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int TICK_WIDTH          = 10;
    localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(CHANGE_WINDOW_CYC - 1);

    localparam int ID_WIDTH = 6;

    typedef struct packed {
        logic [ID_WIDTH-1:0]   id_prev;
        logic [TICK_WIDTH-1:0] tick_cnt;
        logic                  threshold_select;
        logic                  sixth_input_select;
        logic [ID_WIDTH-1:0]   gpio_pol;
        logic                  mask_vc;
        logic [7:0]            config_five;
        logic                  rail12_or_code_change_flag;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [ID_WIDTH-1:0]   io_out;
        logic [ID_WIDTH-1:0]   io_oe_n;
        logic                  pin6_out;
        logic                  pin6_oe_n;
        logic                  alert_oe_n;
    } vim_state_type;

endpackage

/* File: design/vim_sync.sv */
// Two-stage synchroniser for a group of input levels
`timescale 1ns/1ps
module vim_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    stage_one[i] <= 1'b0;
                    sync_out[i]  <= 1'b0;
                end
                else
                begin
                    stage_one[i] <= async_in[i];
                    // First stage feeds only the second
                    sync_out[i]  <= stage_one[i];
                end
            end
        end
    endgenerate

endmodule

/* File: design/vim_monitor.sv */
// Voltage-id input monitor with change detect and general-purpose reuse
`timescale 1ns/1ps
// Functional notes
// - Identification register bits 0 to 4 read the levels of the five dedicated id pins in order.
// - Bit 5 reads zero in 12 V mode and the shared pin level in sixth-input mode.
// - Bit 6 picks the input threshold, 0 for the nominal 1 V and 1 for the reduced 0.6 V.
// - Bit 7 picks the shared pin function, 0 for 12 V measurement and 1 for sixth id input, and reads back.
// - In 12 V mode status two bit 0 reports 12 V out-of-limit results.
// - In sixth-input mode status two bit 0 reports id code changes.
// - Code change detection runs only in sixth-input mode.
// - The change flag sets when the sampled code differs from the one sampled 11 us before.
// - A code change drives the alert output unless mask two bit 0 is set.
// - Config five bit 4 turns every pin now used as id input into a general-purpose output.
// - In general-purpose mode writing an id register bit sets that output's polarity.
// - Config five bits 3:2 set up general-purpose pin six independently.
// - General-purpose pins are numbered 0 to 6, seven in all, with pin 5 only in sixth-input mode.
module vim_monitor
    import vim_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Register access
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    output logic                     reg_rvalid,
    // Id pins 0..4 and shared pin at index 5
    input  wire logic [ID_WIDTH-1:0] id_pin_in,
    output logic      [ID_WIDTH-1:0] id_pin_out,
    output logic      [ID_WIDTH-1:0] id_pin_oe_n,
    // Independent pin six
    input  wire logic                independent_io_pin_in,
    output logic                     independent_io_pin_out,
    output logic                     independent_io_pin_oe_n,
    // Measurement path and analog controls
    input  wire logic                rail12_out_of_limit,
    output logic                     threshold_select,
    output logic                     sixth_input_select,
    // Open-drain alert, wire pulled low while enable is low
    output logic                     alert_oe_n
);

    vim_state_type           cur;
    vim_state_type           next_cur;
    logic [ID_WIDTH:0]       synced;
    logic [ID_WIDTH-1:0]     id_now;
    logic                    pin6_now;
    logic                    gpio_mode;
    logic                    tick;
    logic                    code_changed;
    logic                    wr_hit_id;
    logic                    rd_hit_status;

    vim_sync #(
        .WIDTH (ID_WIDTH + 1)
    ) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in ({independent_io_pin_in, id_pin_in}),
        .sync_out (synced)
    );

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    always_comb
    begin
        id_now       = synced[ID_WIDTH-1:0];
        pin6_now     = synced[ID_WIDTH];
        // Shared bit hidden while pin measures 12 V
        if (!cur.sixth_input_select)
        begin
            id_now[BIT_SHARED_ID] = 1'b0;
        end
        gpio_mode     = cur.config_five[BIT_GPIO_ENABLE];
        tick          = (cur.tick_cnt == TICK_LAST);
        // Raw levels, so switching the shared pin in does not fake a change
        code_changed  = tick && cur.sixth_input_select && (synced[ID_WIDTH-1:0] != cur.id_prev);
        wr_hit_id     = reg_wr && hit(reg_addr, OFS_VOLTAGE_ID_GPIO);
        rd_hit_status = reg_rd && hit(reg_addr, OFS_INT_STATUS_TWO);

        next_cur = cur;

        // Compare sample against the one taken one window earlier
        next_cur.tick_cnt = tick ? '0 : cur.tick_cnt + 1'b1;
        if (tick)
        begin
            next_cur.id_prev = synced[ID_WIDTH-1:0];
        end

        // Register writes
        if (wr_hit_id)
        begin
            next_cur.threshold_select   = reg_wdata[BIT_THRESHOLD_SELECT];
            next_cur.sixth_input_select = reg_wdata[BIT_SIXTH_INPUT_SEL];
            next_cur.gpio_pol           = reg_wdata[ID_WIDTH-1:0];
        end
        if (reg_wr && hit(reg_addr, OFS_INT_MASK_TWO))
        begin
            next_cur.mask_vc = reg_wdata[BIT_MASK_VC];
        end
        if (reg_wr && hit(reg_addr, OFS_CONFIG_FIVE))
        begin
            next_cur.config_five = reg_wdata;
        end

        // Sticky flag: cleared by status read, a new event wins over the clear
        if (rd_hit_status)
        begin
            next_cur.rail12_or_code_change_flag = 1'b0;
        end
        if (cur.sixth_input_select ? code_changed : rail12_out_of_limit)
        begin
            next_cur.rail12_or_code_change_flag = 1'b1;
        end

        // Registered read data, one cycle after the request
        next_cur.rvalid = reg_rd;
        next_cur.rdata  = 8'h00;
        case (1'b1)
            hit(reg_addr, OFS_INT_STATUS_TWO):
                next_cur.rdata[BIT_FLAG_RAIL12_OR_VC] = cur.rail12_or_code_change_flag;
            hit(reg_addr, OFS_VOLTAGE_ID_GPIO):
                next_cur.rdata = {cur.sixth_input_select, cur.threshold_select, id_now};
            hit(reg_addr, OFS_INT_MASK_TWO):
                next_cur.rdata[BIT_MASK_VC] = cur.mask_vc;
            hit(reg_addr, OFS_CONFIG_FIVE):
                next_cur.rdata = cur.config_five;
            default:
                next_cur.rdata = 8'h00;
        endcase
        if (!reg_rd)
        begin
            next_cur.rdata = cur.rdata;
        end

        // Id pins turn to outputs; shared pin only when it is an id input
        next_cur.io_out  = cur.gpio_pol;
        next_cur.io_oe_n = {ID_WIDTH{1'b1}};
        if (gpio_mode)
        begin
            next_cur.io_oe_n = {~cur.sixth_input_select, {(ID_WIDTH-1){1'b0}}};
        end

        // Pin six: dir bit selects output, level bit is the driven value
        next_cur.pin6_oe_n = ~cur.config_five[BIT_PIN6_DIR];
        next_cur.pin6_out  = cur.config_five[BIT_PIN6_LEVEL];

        // Alert follows the sticky flag in sixth-input mode
        next_cur.alert_oe_n = ~(cur.sixth_input_select && cur.rail12_or_code_change_flag && !cur.mask_vc);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cur                            <= '0;
            cur.threshold_select           <= RST_THRESHOLD;
            cur.sixth_input_select         <= RST_SIXTH_SEL;
            cur.gpio_pol                   <= RST_GPIO_POL;
            cur.mask_vc                    <= RST_MASK_VC;
            cur.config_five                <= RST_CONFIG_FIVE;
            cur.io_oe_n                    <= {ID_WIDTH{1'b1}};
            cur.pin6_oe_n                  <= 1'b1;
            cur.alert_oe_n                 <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Pin six input is synchronised but has no register bit
    assign reg_rdata               = cur.rdata;
    assign reg_rvalid              = cur.rvalid;
    assign id_pin_out              = cur.io_out;
    assign id_pin_oe_n             = cur.io_oe_n;
    assign independent_io_pin_out  = cur.pin6_out;
    assign independent_io_pin_oe_n = cur.pin6_oe_n;
    assign threshold_select        = cur.threshold_select;
    assign sixth_input_select      = cur.sixth_input_select;
    assign alert_oe_n              = cur.alert_oe_n;

endmodule

/* File: testbench/vim_sva.sv */
// Port checks for the voltage-id monitor
`timescale 1ns/1ps
module vim_sva
    import vim_pkg::*;
(
    // Watched ports
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic                reg_rvalid,
    input wire logic [ID_WIDTH-1:0] id_pin_oe_n,
    input wire logic                independent_io_pin_oe_n,
    input wire logic                threshold_select,
    input wire logic                sixth_input_select,
    input wire logic                alert_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic wr43;
    logic wr7c;
    assign wr43 = reg_wr && reg_addr == OFS_VOLTAGE_ID_GPIO;
    assign wr7c = reg_wr && reg_addr == OFS_CONFIG_FIVE;
    sequence s_answer; reg_rvalid; endsequence
    sequence s_odd_read; reg_rd && !(reg_addr inside {8'h42, 8'h43, 8'h75, 8'h7c}); endsequence
    property p_rvalid; reg_rd |=> s_answer; endproperty
    property p_unmapped; s_odd_read |=> s_answer ##0 (reg_rdata == 8'h00); endproperty
    property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    // Controls come straight from the registers, one edge after the write
    property p_thr; $changed(threshold_select) |-> $past(wr43); endproperty
    property p_sel; $changed(sixth_input_select) |-> $past(wr43); endproperty
    // Alert only ever asserts in sixth-input mode; it lags the select by one edge
    property p_alert; !$past(sixth_input_select) |-> alert_oe_n; endproperty
    property p_oe; $changed(id_pin_oe_n) |-> $past(wr7c || wr43, 2) && id_pin_oe_n[4:0] == {5{id_pin_oe_n[0]}};
    endproperty
    property p_pin6; $changed(independent_io_pin_oe_n) |-> $past(wr7c, 2); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_thr: assert property (p_thr) else $error("threshold moved without write");
    a_sel: assert property (p_sel) else $error("pin function moved without write");
    a_alert: assert property (p_alert) else $error("alert in 12 V mode");
    a_oe: assert property (p_oe) else $error("bad output enables");
    a_pin6: assert property (p_pin6) else $error("pin six moved without write");
endmodule

/* File: testbench/vim_partner.sv */
// Regulator id lines facing the monitor
`timescale 1ns/1ps
module vim_partner (
    // Levels presented and monitor drive
    input  wire logic [5:0] code,
    input  wire logic [5:0] id_pin_out,
    input  wire logic [5:0] id_pin_oe_n,
    output logic      [5:0] id_pin_in
);
    // Driven pins show the monitor's level
    assign id_pin_in = (code & id_pin_oe_n) | (id_pin_out & ~id_pin_oe_n);
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the voltage-id monitor
`timescale 1ns/1ps
module testbench
    import vim_pkg::*;
();
    logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rail = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic [5:0]  code = 6'h00, pin_in, pin_out, pin_oe_n;
    logic        rvalid, p6_out, p6_oe_n, thr, sel, alert_n;
    logic [31:0] seed = 82;
    logic [7:0]  exp_q[$];
    int          error_cnt = 0, checks = 0;
    vim_monitor i_vim_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .id_pin_in(pin_in),
        .id_pin_out(pin_out), .id_pin_oe_n(pin_oe_n), .independent_io_pin_in(1'b0),
        .independent_io_pin_out(p6_out), .independent_io_pin_oe_n(p6_oe_n), .rail12_out_of_limit(rail),
        .threshold_select(thr), .sixth_input_select(sel), .alert_oe_n(alert_n));
    vim_partner i_vim_partner (.code(code), .id_pin_out(pin_out), .id_pin_oe_n(pin_oe_n), .id_pin_in(pin_in));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    // Pin levels and output states
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] e);
        chk(got, e);
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    // Always flips bit 0 so a change is certain
    task automatic new_code();
        @(posedge sys_clk);
        seed = xorshift(seed);
        code <= code ^ (seed[5:0] | 6'h01);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic stop_test();
        // A read that never answered is a mismatch too
        if (exp_q.size() != 0)
            error_cnt++;
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk)
        if (rvalid === 1'b1 && exp_q.size() > 0)
            chk(rdata, exp_q.pop_front());
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(OFS_INT_STATUS_TWO, 8'h00);
        rd(OFS_INT_MASK_TWO, 8'h00);
        rd(OFS_CONFIG_FIVE, 8'h00);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            new_code();
            rd(OFS_VOLTAGE_ID_GPIO, {3'h0, code[4:0]});
        end
        wr(OFS_VOLTAGE_ID_GPIO, 8'hc0);
        new_code();
        rd(OFS_VOLTAGE_ID_GPIO, {2'h3, code});
        chk_pin({6'h00, thr, sel}, 8'h03);
        repeat (1200) @(posedge sys_clk);
        chk_pin({7'h00, alert_n}, 8'h00);
        rd(OFS_INT_STATUS_TWO, 8'h01);
        repeat (3) @(posedge sys_clk);
        chk_pin({7'h00, alert_n}, 8'h01);
        rd(OFS_INT_STATUS_TWO, 8'h00);
        wr(OFS_INT_MASK_TWO, 8'h01);
        rd(OFS_INT_MASK_TWO, 8'h01);
        new_code();
        repeat (1200) @(posedge sys_clk);
        chk_pin({7'h00, alert_n}, 8'h01);
        rd(OFS_INT_STATUS_TWO, 8'h01);
        wr(OFS_VOLTAGE_ID_GPIO, 8'h00);
        new_code();
        repeat (1200) @(posedge sys_clk);
        rd(OFS_INT_STATUS_TWO, 8'h00);
        @(posedge sys_clk) rail <= 1'b1;
        @(posedge sys_clk) rail <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(OFS_INT_STATUS_TWO, 8'h01);
        wr(OFS_CONFIG_FIVE, 8'h1c);
        wr(OFS_VOLTAGE_ID_GPIO, 8'h15);
        repeat (2) @(posedge sys_clk);
        chk_pin({2'h0, pin_oe_n}, 8'h20);
        chk_pin({2'h0, pin_out}, 8'h15);
        chk_pin({6'h00, p6_out, p6_oe_n}, 8'h02);
        rd(OFS_CONFIG_FIVE, 8'h1c);
        wr(OFS_VOLTAGE_ID_GPIO, 8'hbf);
        repeat (4) @(posedge sys_clk);
        chk_pin({2'h0, pin_oe_n}, 8'h00);
        rd(OFS_VOLTAGE_ID_GPIO, 8'hbf);
        repeat (4) @(posedge sys_clk);
        stop_test();
    end
endmodule
bind vim_monitor vim_sva i_vim_sva (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .id_pin_oe_n, .independent_io_pin_oe_n, .threshold_select, .sixth_input_select, .alert_oe_n);
